// ---- hw/kwu_keypad_wake_unit.v ----
// Keypad wake interrupt unit with AXI4-Lite register slave
`include "kwu_map.vh"

// Functional notes
// [R1] Enabled asserted pin sets pending flag
// [R2] Mask bit blocks interrupt output when one
// [R3] Unmasked request wakes from wait mode
// [R4] Unmasked request wakes from stop mode
// [R5] Break clears allowed when clear enable set
// [R6] Break without clear enable keeps status
// [R7] Two-step clear holds across protected break
// [R8] Each pin has own enable and polarity
// [R9] Enabled pin turns on matching pull device
// [R10] Pending flag read-only, mask independent
// [R11] Acknowledge write-only, clears request, reads zero
// [R12] Sense mode: one edge+level, zero edge
// [R13] Pin enable bit admits pin to detection
// [R14] Reserved enable bit reads zero
// [R15] Polarity one high/rising, zero low/falling
// [R16] Level mode clears after deassert and ack
// [R17] Edge ignored while other pin asserted
// [R18] Reset clears request and sense mode
// [R19] Low sense pulls up, high sense pulls down
// [R20] Pins synchronised by two flip-flops
module kwu_keypad_wake_unit (
  input  wire        i_clock,
  input  wire        i_arst_n,
  input  wire [5:0]  i_keypad_input_pins,
  input  wire        i_vector_fetch_ack,
  input  wire        i_break_state,
  input  wire        i_break_clear_enable,
  input  wire [3:0]  i_s_axi_awaddr,
  input  wire        i_s_axi_awvalid,
  output wire        o_s_axi_awready,
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  input  wire        i_s_axi_wvalid,
  output wire        o_s_axi_wready,
  output reg  [1:0]  o_s_axi_bresp,
  output reg         o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  input  wire [3:0]  i_s_axi_araddr,
  input  wire        i_s_axi_arvalid,
  output wire        o_s_axi_arready,
  output reg  [31:0] o_s_axi_rdata,
  output reg  [1:0]  o_s_axi_rresp,
  output reg         o_s_axi_rvalid,
  input  wire        i_s_axi_rready,
  output wire        o_irq_request,
  output wire        o_wake_request,
  output reg  [5:0]  o_pull_up_en,
  output reg  [5:0]  o_pull_down_en,
  output reg  [5:0]  o_dir_input_force
);
  // Control register state
  reg  [5:0]  pin_enable_q;
  reg  [5:0]  pin_polarity_q;
  reg         sense_mode_q;
  reg         irq_mask_q;

  // Request latch and its acknowledge memory
  reg         latch_q;
  reg         latch_d;
  reg         ack_seen_q;
  reg         ack_seen_d;
  reg  [5:0]  asserted_q;

  // Write channel holding registers
  reg         aw_held_q;
  reg  [3:0]  aw_addr_q;
  reg         w_held_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;

  // Pin detection nets
  wire [5:0]  pin_sync;
  wire [5:0]  asserted;
  wire [5:0]  rise;
  wire        any_asserted;
  wire        edge_hit;
  wire        edge_set;
  wire        level_set;
  wire        level_done;

  // Bus and acknowledge nets
  wire        do_write;
  wire        ack_pulse;
  wire        sw_ack;
  wire        clear_ok;
  wire        request_out;
  wire        pending;
  wire [3:0]  wr_addr;
  wire [31:0] wr_data;

  // Read multiplexer and write response select
  reg  [31:0] rd_word;
  reg  [1:0]  rd_resp;
  reg         wr_okay;

  // Pin synchroniser [R20]
  kwu_pin_sync u_sync (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .i_async  (i_keypad_input_pins),
    .o_sync   (pin_sync)
  );

  // Per-pin assertion by polarity and enable [R8] [R13] [R15]
  genvar g;
  generate
    for (g = 0; g < `KWU_NUM_PINS; g = g + 1) begin : g_pin
      assign asserted[g] = pin_enable_q[g] &
                           ~(pin_sync[g] ^ pin_polarity_q[g]);
      assign rise[g]     = asserted[g] & ~asserted_q[g];
      always @* begin
        o_pull_up_en[g]      = pin_enable_q[g] & ~pin_polarity_q[g];
        o_pull_down_en[g]    = pin_enable_q[g] & pin_polarity_q[g];
        o_dir_input_force[g] = pin_enable_q[g];
      end
    end
  endgenerate
  // Pull device follows polarity when enabled [R9] [R19]

  // Last cycle's detection state for edge finding
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      asserted_q <= 6'h00;
    end else begin
      asserted_q <= asserted;
    end
  end

  // Any enabled pin currently asserted
  assign any_asserted = |asserted;
  // Edge counts only when no other enabled pin was asserted last cycle and still is [R17]
  assign edge_hit = (|rise) & ~(|(asserted_q & asserted));

  // AXI4-Lite write path: address and data taken in either order
  assign o_s_axi_awready = ~aw_held_q & ~o_s_axi_bvalid;
  assign o_s_axi_wready  = ~w_held_q & ~o_s_axi_bvalid;
  assign o_s_axi_arready = ~o_s_axi_rvalid;
  assign wr_addr  = aw_held_q ? aw_addr_q : i_s_axi_awaddr;
  assign wr_data  = w_held_q ? w_data_q : i_s_axi_wdata;
  assign do_write = (aw_held_q | (i_s_axi_awvalid & o_s_axi_awready)) &
                    (w_held_q | (i_s_axi_wvalid & o_s_axi_wready)) &
                    ~o_s_axi_bvalid;

  wire       strb0 = w_held_q ? w_strb_q[0] : i_s_axi_wstrb[0];
  wire       ctl_wr = do_write & strb0 &
                      (wr_addr == `KWU_OFS_STATUS_CONTROL);
  // Acknowledge may clear status in break only with clear enable [R5] [R6] [R7]
  assign clear_ok  = ~i_break_state | i_break_clear_enable;
  assign sw_ack    = ctl_wr & wr_data[`KWU_BIT_REQUEST_ACK];   // [R11]
  assign ack_pulse = (sw_ack | i_vector_fetch_ack) & clear_ok;

  // Only mapped offsets answer OKAY
  always @* begin
    case (wr_addr)
      `KWU_OFS_STATUS_CONTROL,
      `KWU_OFS_PIN_ENABLE,
      `KWU_OFS_PIN_POLARITY: wr_okay = 1'b1;
      default:               wr_okay = 1'b0;
    endcase
  end

  // Write handshake and response
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_held_q      <= 1'b0;
      aw_addr_q      <= 4'h0;
      w_held_q       <= 1'b0;
      w_data_q       <= 32'h00000000;
      w_strb_q       <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `KWU_RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held_q      <= 1'b0;
        w_held_q       <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= wr_okay ? `KWU_RESP_OKAY : `KWU_RESP_SLVERR;
      end else begin
        if (i_s_axi_awvalid & o_s_axi_awready) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid & o_s_axi_wready) begin
          w_held_q <= 1'b1;
          w_data_q <= i_s_axi_wdata;
          w_strb_q <= i_s_axi_wstrb;
        end
        if (o_s_axi_bvalid & i_s_axi_bready) begin
          o_s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Control registers; reset clears the sense mode [R18]
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_enable_q   <= `KWU_RST_PIN_ENABLE;
      pin_polarity_q <= `KWU_RST_PIN_POLARITY;
      sense_mode_q   <= `KWU_RST_SENSE_MODE;
      irq_mask_q     <= `KWU_RST_IRQ_MASK;
    end else if (do_write & strb0) begin
      case (wr_addr)
        `KWU_OFS_STATUS_CONTROL: begin
          sense_mode_q <= wr_data[`KWU_BIT_SENSE_MODE];   // [R12]
          irq_mask_q   <= wr_data[`KWU_BIT_IRQ_MASK];     // [R2]
        end
        `KWU_OFS_PIN_ENABLE:   pin_enable_q   <= wr_data[5:0];
        `KWU_OFS_PIN_POLARITY: pin_polarity_q <= wr_data[5:0];
        default: ;
      endcase
    end
  end

  // Set sources: a fresh edge, or in level mode any asserted pin
  assign edge_set   = edge_hit;                              // [R1]
  assign level_set  = sense_mode_q & any_asserted;           // [R16]

  // Level release needs ack and quiet pins, in either order [R16]
  // A remembered ack cannot finish the clear inside a break without clear enable [R7]
  assign level_done = ~any_asserted & (ack_pulse | ack_seen_q) & clear_ok;

  // Request latch: a new detection wins over a same-cycle acknowledge
  always @* begin
    latch_d = latch_q;
    if (edge_set | level_set) begin
      latch_d = 1'b1;                                        // [R1]
    end else if (sense_mode_q) begin
      if (level_done) begin
        latch_d = 1'b0;                                      // [R16]
      end
    end else if (ack_pulse) begin
      latch_d = 1'b0;                                        // [R11]
    end
  end

  // Acknowledge memory for level mode; a new edge forgets it
  always @* begin
    ack_seen_d = ack_seen_q;
    if (~latch_d) begin
      ack_seen_d = 1'b0;
    end else if (edge_set) begin
      ack_seen_d = 1'b0;
    end else if (ack_pulse) begin
      ack_seen_d = 1'b1;
    end
  end

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      latch_q    <= 1'b0;                                    // [R18]
      ack_seen_q <= 1'b0;
    end else begin
      latch_q    <= latch_d;
      ack_seen_q <= ack_seen_d;
    end
  end

  // Flag and request both follow the latch, mask aside [R10]
  assign pending        = latch_q;
  assign request_out    = latch_q;
  assign o_irq_request  = request_out & ~irq_mask_q;         // [R2]
  // Wake from wait or stop uses the same unmasked request [R3] [R4]
  assign o_wake_request = request_out & ~irq_mask_q;

  // Read path
  always @* begin
    rd_word = 32'h00000000;
    rd_resp = `KWU_RESP_OKAY;
    case (i_s_axi_araddr)
      `KWU_OFS_STATUS_CONTROL: begin
        rd_word[`KWU_BIT_SENSE_MODE]   = sense_mode_q;
        rd_word[`KWU_BIT_IRQ_MASK]     = irq_mask_q;
        rd_word[`KWU_BIT_PENDING_FLAG] = pending;       // [R10]
      end
      `KWU_OFS_PIN_ENABLE:   rd_word[5:0] = pin_enable_q;   // [R14]
      `KWU_OFS_PIN_POLARITY: rd_word[5:0] = pin_polarity_q;
      default:               rd_resp = `KWU_RESP_SLVERR;
    endcase
  end

  // Read answer register, one cycle after the address
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h00000000;
      o_s_axi_rresp  <= `KWU_RESP_OKAY;
    end else if (i_s_axi_arvalid & o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata  <= rd_word;
      o_s_axi_rresp  <= rd_resp;
    end else if (o_s_axi_rvalid & i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ---- hw/kwu_map.vh ----
// Register map and field layout of the keypad wake unit
`ifndef KWU_MAP_VH
`define KWU_MAP_VH
`define KWU_OFS_STATUS_CONTROL 4'h0
`define KWU_OFS_PIN_ENABLE     4'h4
`define KWU_OFS_PIN_POLARITY   4'h8
`define KWU_BIT_SENSE_MODE     0
`define KWU_BIT_IRQ_MASK       1
`define KWU_BIT_REQUEST_ACK    2
`define KWU_BIT_PENDING_FLAG   3
`define KWU_NUM_PINS           6
`define KWU_RST_PIN_ENABLE     6'h00
`define KWU_RST_PIN_POLARITY   6'h00
`define KWU_RST_SENSE_MODE     1'b0
`define KWU_RST_IRQ_MASK       1'b0
`define KWU_RESP_OKAY          2'h0
`define KWU_RESP_SLVERR        2'h2
`endif

// ---- hw/kwu_pin_sync.v ----
// Two-stage synchroniser for the keypad input pins
module kwu_pin_sync (
  input  wire       i_clock,
  input  wire       i_arst_n,
  input  wire [5:0] i_async,
  output wire [5:0] o_sync
);
  reg [5:0] meta_q;
  reg [5:0] sync_q;

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// ---- test/kwu_key_model.sv ----
// Switch model driving the keypad pins
module kwu_key_model (
  input  wire logic       i_clock,
  input  wire logic [5:0] i_press,
  input  wire logic [5:0] i_pull_up,
  input  wire logic [5:0] i_pull_down,
  output logic      [5:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] float_q = 6'h2A;
  always @(posedge i_clock) float_q <= ~float_q;
  // Pressed switch beats the pull device; pins with no pull float
  always_comb o_pins = (i_pull_up & ~i_press) | (i_pull_down & i_press)
                     | (~(i_pull_up | i_pull_down) & float_q);
endmodule

// ---- test/kwu_monitor.sv ----
// Port checker for the keypad wake unit
module kwu_monitor (
  input wire logic        i_clock,
  input wire logic        i_arst_n,
  input wire logic [3:0]  i_s_axi_araddr,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_s_axi_rvalid,
  input wire logic        o_irq_request,
  input wire logic        o_wake_request,
  input wire logic [5:0]  o_pull_up_en,
  input wire logic [5:0]  o_pull_down_en,
  input wire logic [5:0]  o_dir_input_force
);
  logic [3:0] ar_q;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) ar_q <= 4'h0;
    else if (i_s_axi_arvalid && o_s_axi_arready) ar_q <= i_s_axi_araddr;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  sequence s_rd_taken;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  sequence s_st_read;
    $rose(o_s_axi_rvalid) && ar_q == 4'h0;
  endsequence
  a_wake_irq_same: assert property (o_wake_request == o_irq_request)
    else $error("wake and irq differ");
  a_pull_exclusive: assert property (!(|(o_pull_up_en & o_pull_down_en)))
    else $error("pull up and down together");
  a_pull_on_enable: assert property
    ((o_pull_up_en | o_pull_down_en) == o_dir_input_force)
    else $error("pull device not tied to enable");
  a_read_answer: assert property (s_rd_taken |=> o_s_axi_rvalid)
    else $error("read answer late");
  a_read_single: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while answer pending");
  a_ack_reads_zero: assert property (s_st_read |-> !o_s_axi_rdata[2])
    else $error("ack bit reads one");
  a_reserved_zero: assert property ($rose(o_s_axi_rvalid) && ar_q == 4'h4 |-> o_s_axi_rdata[7:6] == 2'h0)
    else $error("reserved enable bits read one");
  a_pend_flag_irq: assert property ((s_st_read ##0 $past(o_irq_request)) |-> o_s_axi_rdata[3])
    else $error("flag clear while irq high");
endmodule
bind kwu_keypad_wake_unit kwu_monitor kwu_monitor_inst (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_s_axi_araddr(i_s_axi_araddr),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rvalid(o_s_axi_rvalid),
  .o_irq_request(o_irq_request), .o_wake_request(o_wake_request),
  .o_pull_up_en(o_pull_up_en), .o_pull_down_en(o_pull_down_en),
  .o_dir_input_force(o_dir_input_force));

// ---- test/tb.sv ----
// Self-checking bench of the keypad wake unit
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0, i_arst_n = 1'b0, i_vector_fetch_ack = 1'b0;
  logic i_break_state = 1'b0, i_break_clear_enable = 1'b0;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic [3:0] i_s_axi_awaddr = 4'h0, i_s_axi_araddr = 4'h0, i_s_axi_wstrb = 4'hF;
  logic [31:0] i_s_axi_wdata = 32'h0, rd_q;
  logic [5:0] press = 6'h00, pol;
  logic [1:0] rs_q;
  wire [5:0] pins, o_pull_up_en, o_pull_down_en, o_dir_input_force;
  wire [31:0] o_s_axi_rdata;
  wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  wire o_s_axi_rvalid, o_irq_request, o_wake_request;
  integer error_cnt = 0, n_checks = 0, seed = 32'h7cd2, k, j;
  always #50 i_clock = ~i_clock;
  kwu_keypad_wake_unit kwu_keypad_wake_unit_inst (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_keypad_input_pins(pins),
    .i_vector_fetch_ack(i_vector_fetch_ack), .i_break_state(i_break_state),
    .i_break_clear_enable(i_break_clear_enable),
    .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
    .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
    .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
    .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp),
    .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
    .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
    .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
    .i_s_axi_rready(i_s_axi_rready), .o_irq_request(o_irq_request),
    .o_wake_request(o_wake_request), .o_pull_up_en(o_pull_up_en),
    .o_pull_down_en(o_pull_down_en), .o_dir_input_force(o_dir_input_force));
  kwu_key_model kwu_key_model_inst (.i_clock(i_clock), .i_press(press),
    .i_pull_up(o_pull_up_en), .i_pull_down(o_pull_down_en), .o_pins(pins));
  function automatic logic [31:0] st(input logic p, m, md);
    st = {28'h0, p, 1'b0, m, md};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, bk;
    @(posedge i_clock);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(negedge i_clock);
      ta = i_s_axi_awvalid & o_s_axi_awready;
      tw = i_s_axi_wvalid & o_s_axi_wready;
      bk = o_s_axi_bvalid;
      @(posedge i_clock);
      if (ta) i_s_axi_awvalid <= 1'b0;
      if (tw) i_s_axi_wvalid <= 1'b0;
    end while (bk !== 1'b1);
    i_s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    logic ta, rv;
    @(posedge i_clock);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(negedge i_clock);
      ta = i_s_axi_arvalid & o_s_axi_arready;
      rv = o_s_axi_rvalid;
      rd_q = o_s_axi_rdata;
      rs_q = o_s_axi_rresp;
      @(posedge i_clock);
      if (ta) i_s_axi_arvalid <= 1'b0;
    end while (rv !== 1'b1);
    i_s_axi_rready <= 1'b0;
  endtask
  task automatic gap();
    repeat (6) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_arst_n <= 1'b1;
    rd(4'h0); chk("status", st(0, 0, 0), rd_q);
    rd(4'h4); chk("enable", 32'h0, rd_q);
    rd(4'hC); chk("resp", 32'h2, {30'h0, rs_q});
    pol = $random(seed);
    k = {$random(seed)} % 6;
    j = (k + 1) % 6;
    wr(4'h8, {26'h0, pol});
    wr(4'h4, 32'h3F);
    rd(4'h4); chk("enable", 32'h3F, rd_q);
    rd(4'h8); chk("polarity", {26'h0, pol}, rd_q);
    chk("pull_up", {26'h0, ~pol}, {26'h0, o_pull_up_en});
    chk("pull_dn", {26'h0, pol}, {26'h0, o_pull_down_en});
    wr(4'h0, 32'h4); gap(); press[k] <= 1'b1; gap();
    chk("irq", 1, o_irq_request);
    rd(4'h0); chk("status", st(1, 0, 0), rd_q);
    wr(4'h0, 32'h4); gap(); chk("irq", 0, o_irq_request);
    press[j] <= 1'b1; gap(); chk("irq", 0, o_irq_request);
    press <= 6'h00; wr(4'h0, 32'h2); press[k] <= 1'b1; gap();
    chk("irq", 0, o_irq_request);
    rd(4'h0); chk("status", st(1, 1, 0), rd_q);
    press <= 6'h00; wr(4'h0, 32'h0); gap(); chk("irq", 1, o_irq_request);
    @(posedge i_clock) i_vector_fetch_ack <= 1'b1;
    @(posedge i_clock) i_vector_fetch_ack <= 1'b0;
    gap(); chk("irq", 0, o_irq_request);
    wr(4'h0, 32'h1); press[k] <= 1'b1; gap(); chk("irq", 1, o_irq_request);
    wr(4'h0, 32'h5); gap(); chk("irq", 1, o_irq_request);
    press <= 6'h00; gap(); chk("irq", 0, o_irq_request);
    wr(4'h4, 32'h3F & ~(32'h1 << k)); press[k] <= 1'b1; gap();
    chk("irq", 0, o_irq_request);
    press <= 6'h00; wr(4'h4, 32'h3F); wr(4'h0, 32'h4); press[j] <= 1'b1; gap();
    press <= 6'h00; i_break_state <= 1'b1; wr(4'h0, 32'h4); gap();
    chk("irq", 1, o_irq_request);
    i_break_clear_enable <= 1'b1; wr(4'h0, 32'h4); gap();
    chk("irq", 0, o_irq_request);
    i_break_state <= 1'b0; i_break_clear_enable <= 1'b0; gap();
    chk("irq", 0, o_irq_request);
    wr(4'h0, 32'h1); press[k] <= 1'b1; gap(); wr(4'h0, 32'h5);
    i_break_state <= 1'b1; press <= 6'h00; gap();
    chk("irq", 1, o_irq_request);
    i_break_state <= 1'b0; gap(); chk("irq", 0, o_irq_request);
    wr(4'h0, 32'h1); press[k] <= 1'b1; gap(); i_arst_n <= 1'b0; gap();
    i_arst_n <= 1'b1; gap(); chk("irq", 0, o_irq_request);
    rd(4'h0); chk("status", st(0, 0, 0), rd_q);
    final_report();
  end
endmodule
